//--- dv/sar_regs_chk.sv
`timescale 1ns/1ps
module sar_regs_chk (
    input logic mclk_i,
    input logic reset_i,
    input logic ce_i,
    input logic s_axi_awvalid_i,
    input logic s_axi_awready_o,
    input logic s_axi_wvalid_i,
    input logic s_axi_wready_o,
    input logic s_axi_bvalid_o,
    input logic s_axi_bready_i,
    input logic s_axi_arvalid_i,
    input logic s_axi_arready_o,
    input logic s_axi_rvalid_o,
    input logic s_axi_rready_i,
    input logic [31:0] s_axi_rdata_o,
    input logic [23:0] computed_m_i,
    input logic sync_clock_o,
    input logic [7:0] extra_attr_o,
    input logic [1:0] stereo_attr_o,
    input logic vtotal_even_o,
    input logic [23:0] stream_m_o,
    input logic [6:0] unit_size_o,
    input logic [2:0] pix_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
            s_axi_wready_o && ce_i ##1 ce_i;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid_i && s_axi_arready_o && ce_i;
    endsequence

    chk_unit_even: assert property (unit_size_o[0] == 1'h0)
        else $error("unit size odd");
    chk_unit_commit: assert property (
        !$stable(unit_size_o) |-> $rose(s_axi_bvalid_o))
        else $error("unit size moved without a write");
    chk_ext_reserved: assert property (extra_attr_o[5:3] == 3'h0)
        else $error("extra flags reserved bits set");
    chk_stereo_map: assert property (
        {stereo_attr_o, vtotal_even_o} == extra_attr_o[2:0])
        else $error("stereo or vtotal field mismatch");
    chk_pix_onehot: assert property ($onehot(pix_mode_o))
        else $error("pixel mode not one-hot");
    chk_async_ratio: assert property (
        $past(ce_i) && !$past(reset_i) && !$past(sync_clock_o)
        |-> stream_m_o == $past(computed_m_i))
        else $error("async ratio not from computed value");
    chk_write_answer: assert property (s_wr_taken |=> s_axi_bvalid_o)
        else $error("write response late");
    chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_b_holds: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    chk_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped or changed");
endmodule

//--- dv/sar_regs_test.sv
`timescale 1ns/1ps
`include "sar_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module sar_regs_test;
    localparam [11:0] LOW = `SAR_OFS_LOW_FLAGS;
    localparam [11:0] EXT = `SAR_OFS_EXTRA_FLAGS;
    localparam [11:0] NUM = `SAR_OFS_NUMERATOR;
    localparam [11:0] UNIT = `SAR_OFS_UNIT_LEN;
    localparam [11:0] DEN = `SAR_OFS_DENOMINATOR;
    localparam [11:0] PIX = `SAR_OFS_PIX_PER_CLK;
    localparam [1:0] OK = `SAR_RESP_OKAY;
    reg mclk_i = 0;
    reg reset_i = 1;
    reg ce = 1'h1;
    reg [11:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, d;
    reg [3:0] wstrb = 0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg [23:0] cm = 0, cn = 0;
    reg [75:0] e;
    wire awready, wready, bvalid, arready, rvalid, vtotal_even_o;
    wire sync_clock_o, dynamic_range_o, ycbcr_colorimetry_o;
    wire audio_clk_override_o, audio_async_o, audio_only_o;
    wire maud_ctrl_o, ext_vsync_sync_o;
    wire [1:0] bresp, rresp, component_format_o, stereo_attr_o;
    wire [31:0] rdata;
    wire [2:0] bit_depth_o, pix_mode_o;
    wire [7:0] extra_attr_o;
    wire [23:0] stream_m_o, stream_n_o;
    wire [6:0] unit_size_o;
    wire [12:0] low_bus = {ext_vsync_sync_o, maud_ctrl_o, audio_only_o,
        audio_async_o, audio_clk_override_o,
        bit_depth_o, ycbcr_colorimetry_o, dynamic_range_o,
        component_format_o, sync_clock_o};
    integer n_fail = 0, checks_done = 0, i;

    always #2.5 mclk_i = ~mclk_i;

    sar_regs u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .computed_m_i(cm), .computed_n_i(cn),
        .sync_clock_o(sync_clock_o), .component_format_o(component_format_o),
        .dynamic_range_o(dynamic_range_o),
        .ycbcr_colorimetry_o(ycbcr_colorimetry_o), .bit_depth_o(bit_depth_o),
        .audio_clk_override_o(audio_clk_override_o),
        .audio_async_o(audio_async_o), .audio_only_o(audio_only_o),
        .maud_ctrl_o(maud_ctrl_o), .ext_vsync_sync_o(ext_vsync_sync_o),
        .extra_attr_o(extra_attr_o),
        .stereo_attr_o(stereo_attr_o), .vtotal_even_o(vtotal_even_o),
        .stream_m_o(stream_m_o), .stream_n_o(stream_n_o),
        .unit_size_o(unit_size_o), .pix_mode_o(pix_mode_o));

    task test_done;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task tmo(input integer n);
        if (n >= 60) begin
            n_fail++;
            test_done;
        end
    endtask

    // Ready is raised only once the answer shows, so the hold path is seen
    task wr(input [11:0] a, input [31:0] v, input [3:0] s, input [1:0] er);
        integer n;
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (n = 0; n < 60; n++) begin
            @(posedge mclk_i);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid && bready)
                break;
            if (bvalid)
                bready <= 1'h1;
        end
        bready <= 1'h0;
        tmo(n);
        `CHK(bresp, er)
    endtask

    task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'h1;
        for (n = 0; n < 60; n++) begin
            @(posedge mclk_i);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid && rready)
                break;
            if (rvalid)
                rready <= 1'h1;
        end
        rready <= 1'h0;
        tmo(n);
        `CHK(rdata, ed)
        `CHK(rresp, er)
    endtask

    // Pixel mode trails the register by one more edge
    task settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    // Address, writable mask, reset value
    function [75:0] ent(input integer k);
        case (k)
            0: ent = {LOW, 32'h0000_1fff, 32'h0000_0000};
            1: ent = {EXT, 32'h0000_00c7, 32'h0000_0000};
            2: ent = {NUM, 32'h00ff_ffff, 32'h0000_0000};
            3: ent = {UNIT, 32'h0000_007e, 32'h0000_0040};
            4: ent = {DEN, 32'h00ff_ffff, 32'h0000_0000};
            default: ent = {PIX, 32'h0000_0007, 32'h0000_0001};
        endcase
    endfunction

    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'h0;
        for (i = 0; i < 6; i++) begin
            e = ent(i);
            rd(e[75:64], e[31:0], OK);
        end
        `CHK(unit_size_o, 7'h40)
        for (i = 0; i < 12; i++) begin
            e = ent(i % 6);
            d = (i < 6) ? 32'hffff_ffff : 32'h5a5a_a5a5;
            wr(e[75:64], d, 4'hf, OK);
            rd(e[75:64], d & e[63:32], OK);
        end
        wr(LOW, 32'h0000_15a9, 4'hf, OK);
        settle;
        `CHK(low_bus, 13'h15a9)
        wr(EXT, 32'h0000_00ff, 4'hf, OK);
        settle;
        `CHK({extra_attr_o, stereo_attr_o, vtotal_even_o}, 11'h63f)
        wr(EXT, 32'h0000_0002, 4'hf, OK);
        settle;
        `CHK({stereo_attr_o, vtotal_even_o}, 3'h2)
        wr(NUM, 32'h0012_3456, 4'hf, OK);
        wr(DEN, 32'h0065_4321, 4'hf, OK);
        cm <= 24'h0a_0b0c;
        cn <= 24'h0d_0e0f;
        settle;
        `CHK({stream_m_o, stream_n_o}, 48'h1234_5665_4321)
        wr(LOW, 32'h0000_0000, 4'hf, OK);
        settle;
        `CHK({stream_m_o, stream_n_o}, 48'h0a0b_0c0d_0e0f)
        // Enable low must freeze the ratio path
        @(posedge mclk_i);
        ce <= 1'h0;
        cm <= 24'h0c_0b0a;
        settle;
        `CHK(stream_m_o, 24'h0a_0b0c)
        @(posedge mclk_i);
        ce <= 1'h1;
        settle;
        `CHK(stream_m_o, 24'h0c_0b0a)
        rd(NUM, 32'h0012_3456, OK);
        rd(DEN, 32'h0065_4321, OK);
        wr(NUM, 32'h1122_3344, 4'h2, OK);
        rd(NUM, 32'h0012_3356, OK);
        wr(UNIT, 32'h0000_0020, 4'hf, OK);
        settle;
        `CHK(unit_size_o, 7'h20)
        wr(UNIT, 32'h0000_0041, 4'hf, OK);
        rd(UNIT, 32'h0000_0040, OK);
        for (i = 0; i < 4; i++) begin
            d = (i == 3) ? 32'h0000_0003 : 32'h0000_0001 << i;
            wr(PIX, d, 4'hf, OK);
            settle;
            `CHK(pix_mode_o, (i == 3) ? 3'h1 : d[2:0])
        end
        // Quad selector drives the four-pixel one-hot mode
        wr(PIX, 32'h0000_0004, 4'hf, OK);
        settle;
        `CHK(pix_mode_o, `SAR_PPC_QUAD)
        // Mid-run reset brings the size back to 64
        wr(UNIT, 32'h0000_0020, 4'hf, OK);
        reset_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'h0;
        `CHK(unit_size_o, 7'h40)
        `CHK(pix_mode_o, `SAR_PPC_SINGLE)
        rd(UNIT, 32'h0000_0040, OK);
        rd(PIX, 32'h0000_0001, OK);
        // Gap past the map answers with an error and no data
        wr(12'h1bc, 32'hffff_ffff, 4'hf, `SAR_RESP_SLVERR);
        rd(12'h1bc, 32'h0000_0000, `SAR_RESP_SLVERR);
        test_done;
    end
endmodule

bind sar_regs sar_regs_chk u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
    .ce_i(ce_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .computed_m_i(computed_m_i), .sync_clock_o(sync_clock_o),
    .extra_attr_o(extra_attr_o), .stereo_attr_o(stereo_attr_o),
    .vtotal_even_o(vtotal_even_o), .stream_m_o(stream_m_o),
    .unit_size_o(unit_size_o), .pix_mode_o(pix_mode_o));

//--- src/sar_map.vh
`ifndef SAR_MAP_VH
`define SAR_MAP_VH

// Register byte offsets
`define SAR_OFS_LOW_FLAGS 12'h1a4
`define SAR_OFS_EXTRA_FLAGS 12'h1a8
`define SAR_OFS_NUMERATOR 12'h1ac
`define SAR_OFS_UNIT_LEN 12'h1b0
`define SAR_OFS_DENOMINATOR 12'h1b4
`define SAR_OFS_PIX_PER_CLK 12'h1b8

// Field widths
`define SAR_LOW_W 13
`define SAR_EXTRA_W 8
`define SAR_RATIO_W 24
`define SAR_UNIT_W 7
`define SAR_PPC_W 3

// Field positions in stream_attr_low_flags
`define SAR_LOW_SYNC_CLK 0
`define SAR_LOW_FMT_LO 1
`define SAR_LOW_FMT_HI 2
`define SAR_LOW_RANGE 3
`define SAR_LOW_COLORIM 4
`define SAR_LOW_DEPTH_LO 5
`define SAR_LOW_DEPTH_HI 7
`define SAR_LOW_AUD_OVR 8
`define SAR_LOW_AUD_ASYNC 9
`define SAR_LOW_AUD_ONLY 10
`define SAR_LOW_MAUD 11
`define SAR_LOW_EXT_VSYNC 12

// Field positions in stream_attr_extra_flags
`define SAR_EXT_VT_EVEN 0
`define SAR_EXT_STEREO_LO 1
`define SAR_EXT_STEREO_HI 2
`define SAR_EXT_WR_MASK 8'hc7

// Reset values
`define SAR_LOW_RST 13'h0000
`define SAR_EXTRA_RST 8'h00
`define SAR_RATIO_RST 24'h00_0000
`define SAR_UNIT_RST 7'h40
`define SAR_PPC_RST 3'h1

// Pixel width selector codes
`define SAR_PPC_SINGLE 3'h1
`define SAR_PPC_DUAL 3'h2
`define SAR_PPC_QUAD 3'h4

// Bus answers
`define SAR_RESP_OKAY 2'h0
`define SAR_RESP_SLVERR 2'h2

`endif

//--- src/sar_regs.v
// Function
// - Low flags hold depth, colorimetry, range, format, sync
// - Low flags bit 8 overrides audio clocking
// - Extra flags byte, bits 5:3 reserved
// - Extra flags bits 2:1 give stereo attribute
// - Extra flags bit 0 marks even vertical total
// - Async: device computes M, no readback
// - Async: N register reads only written value
// - Transfer unit size resets to 64
// - Unit size bit 0 ignores writes
// - Pixel selector: 1, 2 or 4 pixels
// - Low flags bit 10 enables audio-only mode
`timescale 1ns/1ps
`include "sar_map.vh"

module sar_regs #(
    parameter ADDR_W = 12
) (
    input wire mclk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire [23:0] computed_m_i,
    input wire [23:0] computed_n_i,
    output wire sync_clock_o,
    output wire [1:0] component_format_o,
    output wire dynamic_range_o,
    output wire ycbcr_colorimetry_o,
    output wire [2:0] bit_depth_o,
    output wire audio_clk_override_o,
    output wire audio_async_o,
    output wire audio_only_o,
    output wire maud_ctrl_o,
    output wire ext_vsync_sync_o,
    output wire [7:0] extra_attr_o,
    output wire [1:0] stereo_attr_o,
    output wire vtotal_even_o,
    output wire [23:0] stream_m_o,
    output wire [23:0] stream_n_o,
    output wire [6:0] unit_size_o,
    output wire [2:0] pix_mode_o
);

    // Byte-lane merge of a write into an old word
    function [31:0] sar_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            sar_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    sar_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode: nonzero when the word offset is mapped
    function sar_hit;
        input [ADDR_W-1:0] addr;
        begin
            case (addr[11:0] & 12'hffc)
                `SAR_OFS_LOW_FLAGS,
                `SAR_OFS_EXTRA_FLAGS,
                `SAR_OFS_NUMERATOR,
                `SAR_OFS_UNIT_LEN,
                `SAR_OFS_DENOMINATOR,
                `SAR_OFS_PIX_PER_CLK: sar_hit = 1'b1;
                default: sar_hit = 1'b0;
            endcase
        end
    endfunction

    // Selector to one-hot pixel mode; unknown codes fall back to single
    function [2:0] sar_pix_decode;
        input [2:0] sel;
        begin
            case (sel)
                `SAR_PPC_DUAL: sar_pix_decode = 3'h2;
                `SAR_PPC_QUAD: sar_pix_decode = 3'h4;
                default: sar_pix_decode = 3'h1;
            endcase
        end
    endfunction

    reg [`SAR_LOW_W-1:0] low_ff;
    reg [`SAR_EXTRA_W-1:0] extra_ff;
    reg [`SAR_RATIO_W-1:0] num_ff;
    reg [`SAR_RATIO_W-1:0] den_ff;
    reg [`SAR_UNIT_W-1:0] unit_ff;
    reg [`SAR_PPC_W-1:0] ppc_ff;

    reg aw_full_ff;
    reg w_full_ff;
    reg [ADDR_W-1:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg awready_ff;
    reg wready_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rdata_ff;

    reg [23:0] stream_m_ff;
    reg [23:0] stream_n_ff;
    reg [2:0] pix_mode_ff;

    wire aw_take = s_axi_awvalid_i & awready_ff;
    wire w_take = s_axi_wvalid_i & wready_ff;
    wire nxt_aw_full = aw_full_ff | aw_take;
    wire nxt_w_full = w_full_ff | w_take;
    wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire b_done = bvalid_ff & s_axi_bready_i;
    wire ar_take = s_axi_arvalid_i & arready_ff;
    wire r_done = rvalid_ff & s_axi_rready_i;

    wire [11:0] wr_ofs = aw_addr_ff[11:0] & 12'hffc;
    wire wr_hit = sar_hit(aw_addr_ff);

    reg [31:0] rd_word;
    reg [31:0] wr_old;
    wire [31:0] wr_new = sar_merge(wr_old, w_data_ff, w_strb_ff);

    // Current contents as seen by software, zero-extended
    always @* begin
        case (s_axi_araddr_i[11:0] & 12'hffc)
            `SAR_OFS_LOW_FLAGS: rd_word = {19'h0_0000, low_ff};
            `SAR_OFS_EXTRA_FLAGS: rd_word = {24'h00_0000, extra_ff};
            `SAR_OFS_NUMERATOR: rd_word = {8'h00, num_ff};
            `SAR_OFS_UNIT_LEN: rd_word = {25'h000_0000, unit_ff};
            `SAR_OFS_DENOMINATOR: rd_word = {8'h00, den_ff};
            `SAR_OFS_PIX_PER_CLK: rd_word = {29'h0000_0000, ppc_ff};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always @* begin
        case (wr_ofs)
            `SAR_OFS_LOW_FLAGS: wr_old = {19'h0_0000, low_ff};
            `SAR_OFS_EXTRA_FLAGS: wr_old = {24'h00_0000, extra_ff};
            `SAR_OFS_NUMERATOR: wr_old = {8'h00, num_ff};
            `SAR_OFS_UNIT_LEN: wr_old = {25'h000_0000, unit_ff};
            `SAR_OFS_DENOMINATOR: wr_old = {8'h00, den_ff};
            `SAR_OFS_PIX_PER_CLK: wr_old = {29'h0000_0000, ppc_ff};
            default: wr_old = 32'h0000_0000;
        endcase
    end

    // Write channel: address and data held independently, then committed
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            aw_addr_ff <= {ADDR_W{1'b0}};
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SAR_RESP_OKAY;
        end else if (ce_i) begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata_i;
                w_strb_ff <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `SAR_RESP_OKAY : `SAR_RESP_SLVERR;
            end else begin
                aw_full_ff <= nxt_aw_full;
                w_full_ff <= nxt_w_full;
                if (b_done) begin
                    bvalid_ff <= 1'b0;
                end
            end
            // Each ready drops while its own half is parked or a response is pending
            awready_ff <= ~nxt_aw_full & ~do_write & ~bvalid_ff;
            wready_ff <= ~nxt_w_full & ~do_write & ~bvalid_ff;
        end
    end

    // Read channel: one outstanding read, data captured at address accept
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `SAR_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                arready_ff <= 1'b0;
                rdata_ff <= rd_word;
                rresp_ff <= sar_hit(s_axi_araddr_i) ?
                    `SAR_RESP_OKAY : `SAR_RESP_SLVERR;
            end else if (r_done) begin
                rvalid_ff <= 1'b0;
            end else if (~rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    // Write selects, one per register
    wire wr_low = do_write & (wr_ofs == `SAR_OFS_LOW_FLAGS);
    wire wr_extra = do_write & (wr_ofs == `SAR_OFS_EXTRA_FLAGS);
    wire wr_num = do_write & (wr_ofs == `SAR_OFS_NUMERATOR);
    wire wr_unit = do_write & (wr_ofs == `SAR_OFS_UNIT_LEN);
    wire wr_den = do_write & (wr_ofs == `SAR_OFS_DENOMINATOR);
    wire wr_ppc = do_write & (wr_ofs == `SAR_OFS_PIX_PER_CLK);

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            low_ff <= `SAR_LOW_RST;
        end else if (ce_i && wr_low) begin
            low_ff <= wr_new[`SAR_LOW_W-1:0];
        end
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            extra_ff <= `SAR_EXTRA_RST;
        end else if (ce_i && wr_extra) begin
            extra_ff <= wr_new[7:0] & `SAR_EXT_WR_MASK;
        end
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            num_ff <= `SAR_RATIO_RST;
        end else if (ce_i && wr_num) begin
            num_ff <= wr_new[23:0];
        end
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            unit_ff <= `SAR_UNIT_RST;
        end else if (ce_i && wr_unit) begin
            unit_ff <= {wr_new[6:1], 1'h0};
        end
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            den_ff <= `SAR_RATIO_RST;
        end else if (ce_i && wr_den) begin
            den_ff <= wr_new[23:0];
        end
    end

    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ppc_ff <= `SAR_PPC_RST;
        end else if (ce_i && wr_ppc) begin
            ppc_ff <= wr_new[2:0];
        end
    end

    // Ratio and pixel mode drive; async values never land in the regs
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            stream_m_ff <= 24'h00_0000;
            stream_n_ff <= 24'h00_0000;
            pix_mode_ff <= 3'h1;
        end else if (ce_i) begin
            if (low_ff[`SAR_LOW_SYNC_CLK]) begin
                stream_m_ff <= num_ff;
                stream_n_ff <= den_ff;
            end else begin
                stream_m_ff <= computed_m_i;
                stream_n_ff <= computed_n_i;
            end
            pix_mode_ff <= sar_pix_decode(ppc_ff);
        end
    end

    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;

    assign sync_clock_o = low_ff[`SAR_LOW_SYNC_CLK];
    assign component_format_o = low_ff[`SAR_LOW_FMT_HI:`SAR_LOW_FMT_LO];
    assign dynamic_range_o = low_ff[`SAR_LOW_RANGE];
    assign ycbcr_colorimetry_o = low_ff[`SAR_LOW_COLORIM];
    assign bit_depth_o = low_ff[`SAR_LOW_DEPTH_HI:`SAR_LOW_DEPTH_LO];
    assign audio_clk_override_o = low_ff[`SAR_LOW_AUD_OVR];
    assign audio_async_o = low_ff[`SAR_LOW_AUD_ASYNC];
    assign audio_only_o = low_ff[`SAR_LOW_AUD_ONLY];
    assign maud_ctrl_o = low_ff[`SAR_LOW_MAUD];
    assign ext_vsync_sync_o = low_ff[`SAR_LOW_EXT_VSYNC];
    assign extra_attr_o = extra_ff;
    assign stereo_attr_o = extra_ff[`SAR_EXT_STEREO_HI:`SAR_EXT_STEREO_LO];
    assign vtotal_even_o = extra_ff[`SAR_EXT_VT_EVEN];
    assign stream_m_o = stream_m_ff;
    assign stream_n_o = stream_n_ff;
    assign unit_size_o = unit_ff;
    assign pix_mode_o = pix_mode_ff;

endmodule
